// ---- verilog/rsc_top.sv ----
// reset, system-management and clock-stop control for the processor core
// assumes core status inputs are on sys_clk; pin inputs are asynchronous

`timescale 1ns/1ps

module rsc_top
  import rsc_pkg::*;
#(
  parameter int LINES = rsc_pkg::CACHE_LINES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      hw_reset,
  input  wire logic                      cache_flush_req_n,
  input  wire logic                      soft_init,
  input  wire logic                      sys_mgmt_irq_n,
  input  wire logic                      core_clock_stop_req_n,
  input  wire logic                      ratio_strap_lo,
  input  wire logic                      ratio_strap_hi,
  input  wire logic                      insn_boundary,
  input  wire logic                      higher_irq_pending,
  input  wire logic                      smm_resume,
  input  wire logic                      snoop_req,
  input  wire logic [rsc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  output logic                           irq,
  output logic                           sys_mgmt_active_n,
  output logic                           core_clk_en,
  output logic                           exec_start,
  output logic                           exec_resume,
  output logic                           stop_grant_cycle,
  output logic                           snoop_ack,
  output logic                           cache_inval,
  output logic      [$clog2(LINES)-1:0]  cache_inval_idx,
  output logic                           wb_suppress,
  output rsc_pkg::rsc_mode_type          reset_mode,
  output rsc_pkg::rsc_ratio_type         ratio_sel
);
  import rsc_pkg::*;

  localparam int IDX_W = $clog2(LINES);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(LINES - 1);

  // -------------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------------
  logic [SYNC_W-1:0] sync_q;
  logic hw_reset_s, flush_n_s, init_s, smi_n_s, stop_n_s, strap_lo_s, strap_hi_s;

  rsc_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .d       ({ratio_strap_hi, ratio_strap_lo, core_clock_stop_req_n, sys_mgmt_irq_n,
                soft_init, cache_flush_req_n, hw_reset}),
    .q       (sync_q)
  );

  assign {strap_hi_s, strap_lo_s, stop_n_s, smi_n_s, init_s, flush_n_s, hw_reset_s} = sync_q;

  // -------------------------------------------------------------------------
  // control state
  // -------------------------------------------------------------------------
  rsc_state_type  state_r,      state_nxt;
  logic [IDX_W-1:0] idx_r,      idx_nxt;
  logic           smi_pend_r,   smi_pend_nxt;
  logic           smi_prev_r,   smi_prev_nxt;
  logic           hw_prev_r,    hw_prev_nxt;
  rsc_mode_type   mode_r,       mode_nxt;
  rsc_ratio_type  ratio_r,      ratio_nxt;
  logic           smact_n_r,    smact_n_nxt;
  logic           clk_en_r,     clk_en_nxt;
  logic           start_r,      start_nxt;
  logic           resume_r,     resume_nxt;
  logic           grant_r,      grant_nxt;
  logic           snoop_r,      snoop_nxt;
  logic           inval_r,      inval_nxt;
  logic           wbsup_r,      wbsup_nxt;
  logic [EVT_W-1:0] evt_set;

  always_comb begin
    state_nxt    = state_r;
    idx_nxt      = '0;
    smi_prev_nxt = smi_n_s;
    hw_prev_nxt  = hw_reset_s;
    mode_nxt     = mode_r;
    ratio_nxt    = ratio_r;
    unique case (state_r)
      ST_RESET:   if (!hw_reset_s) state_nxt = ST_INVAL;          // see R1
      ST_INVAL: begin
        idx_nxt = idx_r + IDX_W'(1);                              // see R2
        if (idx_r == IDX_LAST) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (insn_boundary) begin
          if (smi_pend_r) state_nxt = ST_SMM;                     // see R6
          else if (higher_irq_pending) state_nxt = ST_RUN;        // see R9
          else if (!stop_n_s) state_nxt = ST_GRANT;               // see R8
        end
      end
      ST_GRANT:   state_nxt = ST_STOPPED;                         // see R10
      ST_STOPPED: if (stop_n_s) state_nxt = ST_RUN;               // see R17
      ST_SMM:     if (smm_resume) state_nxt = ST_RUN;
      default:    state_nxt = ST_RESET;
    endcase
    if (hw_reset_s) begin
      state_nxt = ST_RESET;                                       // see R1
      ratio_nxt = rsc_ratio_type'({strap_hi_s, strap_lo_s});      // see R12 see R13 see R16
    end
    if (hw_prev_r && !hw_reset_s) mode_nxt = rsc_mode_decode(flush_n_s, init_s); // see R4
    // set wins over the clear taken on smm entry
    smi_pend_nxt = (smi_pend_r && state_nxt != ST_SMM) || (smi_prev_r && !smi_n_s); // see R5
    smact_n_nxt  = (state_nxt != ST_SMM);                         // see R7
    clk_en_nxt   = (state_nxt != ST_STOPPED);                     // see R8
    start_nxt    = (state_r == ST_INVAL) && (state_nxt == ST_RUN);
    resume_nxt   = (state_r == ST_STOPPED) && (state_nxt == ST_RUN);
    grant_nxt    = (state_nxt == ST_GRANT);                       // see R10
    snoop_nxt    = snoop_req;                                     // see R11
    inval_nxt    = (state_nxt == ST_INVAL);                       // see R2
    // writes stay blocked through reset and the whole walk: modified lines are dropped
    wbsup_nxt    = (state_nxt == ST_RESET) || (state_nxt == ST_INVAL); // see R3
    evt_set             = '0;
    evt_set[EVT_SMM]    = (state_r != ST_SMM) && (state_nxt == ST_SMM);
    evt_set[EVT_GRANT]  = grant_nxt;
    evt_set[EVT_START]  = start_nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r    <= ST_RESET;
      idx_r      <= '0;
      smi_pend_r <= 1'b0;
      smi_prev_r <= 1'b1;
      hw_prev_r  <= 1'b1;
      mode_r     <= MODE_NORMAL;
      ratio_r    <= RATIO_RST;
      smact_n_r  <= 1'b1;
      clk_en_r   <= 1'b1;
      start_r    <= 1'b0;
      resume_r   <= 1'b0;
      grant_r    <= 1'b0;
      snoop_r    <= 1'b0;
      inval_r    <= 1'b0;
      wbsup_r    <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      idx_r      <= idx_nxt;
      smi_pend_r <= smi_pend_nxt;
      smi_prev_r <= smi_prev_nxt;
      hw_prev_r  <= hw_prev_nxt;
      mode_r     <= mode_nxt;
      ratio_r    <= ratio_nxt;
      smact_n_r  <= smact_n_nxt;
      clk_en_r   <= clk_en_nxt;
      start_r    <= start_nxt;
      resume_r   <= resume_nxt;
      grant_r    <= grant_nxt;
      snoop_r    <= snoop_nxt;
      inval_r    <= inval_nxt;
      wbsup_r    <= wbsup_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // register slave and interrupt
  // -------------------------------------------------------------------------
  logic [EVT_W-1:0] status_r, status_nxt;
  logic [EVT_W-1:0] mask_r,   mask_nxt;
  logic [31:0]      rdata_r,  rdata_nxt;
  logic             irq_r,    irq_nxt;

  always_comb begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    rdata_nxt  = '0;
    if (reg_wr && reg_addr == OFS_STATUS) status_nxt = status_r & ~reg_wdata[EVT_W-1:0];
    if (reg_wr && reg_addr == OFS_MASK)   mask_nxt   = reg_wdata[EVT_W-1:0];
    status_nxt = status_nxt | evt_set;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_STATUS: rdata_nxt = {29'h0, status_r};
        OFS_MASK:   rdata_nxt = {29'h0, mask_r};
        OFS_STATE:  rdata_nxt = {22'h0, smi_pend_r, state_r, mode_r, ratio_r,
                                 smact_n_r, clk_en_r};
        default:    rdata_nxt = '0;
      endcase
    end
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= STATUS_RST;
      mask_r   <= MASK_RST;
      rdata_r  <= '0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      rdata_r  <= rdata_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign irq               = irq_r;
  assign sys_mgmt_active_n = smact_n_r;
  assign core_clk_en       = clk_en_r;
  assign exec_start        = start_r;
  assign exec_resume       = resume_r;
  assign stop_grant_cycle  = grant_r;
  assign snoop_ack         = snoop_r;
  assign cache_inval       = inval_r;
  assign cache_inval_idx   = idx_r;
  assign wb_suppress       = wbsup_r;
  assign reset_mode        = mode_r;
  assign ratio_sel         = ratio_r;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_grant_entry;
    $rose(state_r == ST_GRANT) && stop_grant_cycle;
  endsequence
  sequence s_clock_off;
    !core_clk_en && state_r == ST_STOPPED;
  endsequence

  a_reset_state: assert property (hw_reset_s |=> state_r == ST_RESET && wb_suppress) // see R1
    else $error("reset did not force the reset state");
  a_inval_walk: assert property (state_r == ST_INVAL && cache_inval_idx == IDX_LAST // see R2
                                 |=> state_r == ST_RUN && exec_start && !cache_inval)
    else $error("invalidation walk did not end on the last line");
  a_no_writeback: assert property (cache_inval |-> wb_suppress) // see R3
    else $error("write-back allowed during invalidation");
  a_mode_sample: assert property ($fell(hw_reset_s) // see R4
                   |=> reset_mode == rsc_mode_decode($past(flush_n_s), $past(init_s)))
    else $error("reset mode not sampled at reset release");
  a_smi_latch: assert property (smi_prev_r && !smi_n_s && state_r == ST_RUN // see R5
                                |=> smi_pend_r || state_r == ST_SMM)
    else $error("system-management request lost");
  a_smm_boundary: assert property ($rose(state_r == ST_SMM) |-> $past(insn_boundary)) // see R6
    else $error("smm entered away from an instruction boundary");
  a_smm_active: assert property (sys_mgmt_active_n == (state_r != ST_SMM)) // see R7
    else $error("mode-active output disagrees with smm state");
  a_grant_cycle: assert property ($rose(state_r == ST_GRANT) // see R10
                                  |-> s_grant_entry ##1 s_clock_off)
    else $error("stop grant not followed by clock stop");
  a_irq_first: assert property (state_r == ST_RUN && insn_boundary && !smi_pend_r // see R9
                                && higher_irq_pending && !hw_reset_s |=> state_r == ST_RUN)
    else $error("stop taken ahead of a pending interrupt");
  a_snoop_served: assert property (state_r == ST_STOPPED && snoop_req |=> snoop_ack) // see R11
    else $error("snoop not answered while stopped");
  a_ratio_hold: assert property (!hw_reset_s |=> $stable(ratio_sel)) // see R16
    else $error("ratio changed outside reset");
  a_clock_restart: assert property (state_r == ST_STOPPED && stop_n_s && !hw_reset_s // see R17
                                    |=> core_clk_en && exec_resume && state_r == ST_RUN)
    else $error("core clock not restarted after stop release");

  // -------------------------------------------------------------------------
  // pulse widths and hand-offs
  // -------------------------------------------------------------------------
  a_grant_pulse: assert property (stop_grant_cycle |=> !stop_grant_cycle) // see R10
    else $error("stop grant cycle longer than one clock");
  a_start_pulse: assert property (exec_start |=> !exec_start) // see R1
    else $error("execution start pulse longer than one clock");
  a_resume_pulse: assert property (exec_resume |=> !exec_resume) // see R17
    else $error("execution resume pulse longer than one clock");
  a_smi_taken: assert property (state_r == ST_RUN && insn_boundary && smi_pend_r // see R6
                                && !hw_reset_s |=> state_r == ST_SMM)
    else $error("pending system-management request not taken at a boundary");
  a_smm_exit: assert property (state_r == ST_SMM && smm_resume && !hw_reset_s // see R7
                               |=> sys_mgmt_active_n && state_r == ST_RUN)
    else $error("mode-active output not released on smm exit");
  a_smm_hold: assert property (!sys_mgmt_active_n && !smm_resume && !hw_reset_s // see R7
                               |=> !sys_mgmt_active_n)
    else $error("mode-active output dropped while still in smm");
  a_stop_boundary: assert property ($rose(state_r == ST_GRANT) // see R9
                                    |-> $past(insn_boundary && !higher_irq_pending))
    else $error("stop granted away from a boundary or ahead of an interrupt");
  a_stop_held: assert property (state_r == ST_STOPPED && !stop_n_s && !hw_reset_s // see R8
                                |=> state_r == ST_STOPPED && !core_clk_en)
    else $error("core clock restarted while stop still requested");
  a_ratio_capture: assert property (hw_reset_s // see R12
                     |=> ratio_sel == rsc_ratio_type'($past({strap_hi_s, strap_lo_s})))
    else $error("ratio strap not captured while reset held");
  a_inval_order: assert property (cache_inval && cache_inval_idx != IDX_LAST && !hw_reset_s // see R2
                   |=> cache_inval && cache_inval_idx == $past(cache_inval_idx) + IDX_W'(1))
    else $error("invalidation walk skipped or repeated a line");
  a_wb_release: assert property (exec_start |-> !wb_suppress) // see R3
    else $error("write-back still blocked when execution starts");

endmodule : rsc_top

// ---- verilog/rsc_pkg.sv ----
// constants, types and the pin synchroniser for the reset / smm / clock-stop control block
// assumes a single 40 MHz sys_clk and an asynchronous active-low rst_b
//
// Functional notes
// R1: hardware reset sets a defined state; execution starts from it after release.
// R2: hardware reset invalidates every code and data cache entry.
// R3: reset invalidation drops modified lines with no write-back cycles.
// R4: flush and soft init sampled at reset fall select tristate, checker or self test.
// R5: a system-management interrupt sets a pending latch that outlives the input.
// R6: a pending system-management request is taken only at an instruction boundary.
// R7: the mode-active output is asserted exactly while in system management mode.
// R8: stop-clock assertion is a request to halt the core clock.
// R9: stop at next instruction boundary; a pending higher-priority interrupt goes first.
// R10: honouring a stop runs a stop-grant acknowledge cycle.
// R11: snoop and interprocessor requests are still served while stop-clock is held.
// R12: strap decode: 01 is 1/3, 00 is 2/5, 10 is 1/2, 11 reserved.
// R13: both strap pins left open give the 1/2 ratio.
// R14: the system straps only the ratio that the part is qualified for.
// R15: the system keeps the bus clock between 33 and 66 MHz.
// R16: strap captured while reset is held and kept until the next reset.
// R17: stop-clock release after a grant restarts the clock and resumes execution.

`timescale 1ns/1ps

package rsc_pkg;

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam int         ADDR_W        = 4;
  localparam logic [3:0] OFS_STATUS    = 4'h0;
  localparam logic [3:0] OFS_MASK      = 4'h4;
  localparam logic [3:0] OFS_STATE     = 4'h8;
  localparam int         EVT_W         = 3;
  localparam int         EVT_SMM       = 0;
  localparam int         EVT_GRANT     = 1;
  localparam int         EVT_START     = 2;
  localparam logic [2:0] STATUS_RST    = 3'h0;
  localparam logic [2:0] MASK_RST      = 3'h0;

  // -------------------------------------------------------------------------
  // synchroniser layout {strap_hi, strap_lo, stop_n, smi_n, init, flush_n, hw_reset}
  // -------------------------------------------------------------------------
  localparam int         SYNC_W        = 7;
  localparam logic [6:0] SYNC_RST      = 7'h5b;
  localparam int         CACHE_LINES   = 512;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET   = 3'h0,
    ST_INVAL   = 3'h1,
    ST_RUN     = 3'h3,
    ST_GRANT   = 3'h2,
    ST_STOPPED = 3'h6,
    ST_SMM     = 3'h7
  } rsc_state_type;

  typedef enum logic [1:0] {
    RATIO_2_5  = 2'h0,
    RATIO_1_3  = 2'h1,
    RATIO_1_2  = 2'h2,
    RATIO_RSVD = 2'h3
  } rsc_ratio_type;

  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'h0,
    MODE_TRISTATE = 2'h1,
    MODE_CHECKER  = 2'h2,
    MODE_SELFTEST = 2'h3
  } rsc_mode_type;

  localparam rsc_ratio_type RATIO_RST = RATIO_1_2;

  function automatic rsc_mode_type rsc_mode_decode(input logic flush_n, input logic init);
    rsc_mode_type m;
    m = MODE_NORMAL;
    if (!flush_n && init) m = MODE_CHECKER;
    else if (!flush_n)    m = MODE_TRISTATE;
    else if (init)        m = MODE_SELFTEST;
    return m;
  endfunction : rsc_mode_decode

endpackage : rsc_pkg

// two-flop synchroniser; stage one feeds stage two only
module rsc_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : rsc_sync

// ---- verif/rsc_chipset_model.sv ----
// chipset model: drives the reset, mode, interrupt, stop and strap pins of the block
// assumes the bench clock; pins change by nba just after a rising edge
`timescale 1ns/1ps
module rsc_chipset_model (
  input  wire logic sys_clk,
  output logic      hw_reset,
  output logic      cache_flush_req_n,
  output logic      soft_init,
  output logic      sys_mgmt_irq_n,
  output logic      core_clock_stop_req_n,
  output logic      ratio_strap_lo,
  output logic      ratio_strap_hi
);
  // ---------------------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------------------
  initial begin
    hw_reset              = 1'b1;
    cache_flush_req_n     = 1'b1;
    soft_init             = 1'b0;
    sys_mgmt_irq_n        = 1'b1;
    core_clock_stop_req_n = 1'b1;
    ratio_strap_lo        = 1'b0;
    ratio_strap_hi        = 1'b1;
  end

  // open straps fall to the board pulls: low half down, high half up
  task automatic set_strap(input logic [1:0] code, input bit open);
    @(posedge sys_clk);
    ratio_strap_lo <= open ? 1'b0 : code[0];
    ratio_strap_hi <= open ? 1'b1 : code[1];
  endtask : set_strap

  // mode pins settle before the falling edge and stay until mode_idle
  task automatic reset_pulse(input logic flush_n, input logic init);
    @(posedge sys_clk);
    hw_reset          <= 1'b1;
    cache_flush_req_n <= flush_n;
    soft_init         <= init;
    repeat (4) @(posedge sys_clk);
    hw_reset <= 1'b0;
  endtask : reset_pulse

  task automatic mode_idle;
    @(posedge sys_clk);
    cache_flush_req_n <= 1'b1;
    soft_init         <= 1'b0;
  endtask : mode_idle

  // held long enough to cross the synchroniser, then back to the pull-up
  task automatic smi_pulse;
    @(posedge sys_clk);
    sys_mgmt_irq_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    sys_mgmt_irq_n <= 1'b1;
  endtask : smi_pulse

  task automatic set_stop(input logic level_n);
    @(posedge sys_clk);
    core_clock_stop_req_n <= level_n;
  endtask : set_stop
endmodule : rsc_chipset_model

// ---- verif/testbench.sv ----
// self-checking bench for the reset / smm / clock-stop control block
// assumes the design package and the chipset model file compiled first
`timescale 1ns/1ps
module testbench;
  import rsc_pkg::*;
  // ---------------------------------------------------------------------------
  // signals and tables
  // ---------------------------------------------------------------------------
  localparam int LN = 8;
  logic          sys_clk, rst_b, hwr, fl_n, ini, smi_n, stp_n, s_lo, s_hi, bnd, hip, res;
  logic          snp, wr, rd, irq, sa_n, ce, xs, xr, gnt, sak, inv, wbs;
  logic [3:0]    addr;
  logic [2:0]    idx;
  logic [31:0]   wd, rdat, lfsr, exp_q[$];
  rsc_mode_type  mode;
  rsc_ratio_type ratio;
  logic          rd_q = 1'b0;
  int            fail_count = 0, check_count = 0, gcnt = 0, i, n;
  logic [1:0]    sc[4] = '{2'b00, 2'b10, 2'b11, 2'b01};
  logic          tf[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic          ti[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  rsc_mode_type  em[4] = '{MODE_TRISTATE, MODE_CHECKER, MODE_SELFTEST, MODE_NORMAL};
  rsc_ratio_type er[4] = '{RATIO_2_5, RATIO_1_2, RATIO_RSVD, RATIO_1_3};

  rsc_top #(.LINES(LN)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .hw_reset(hwr),
    .cache_flush_req_n(fl_n), .soft_init(ini), .sys_mgmt_irq_n(smi_n),
    .core_clock_stop_req_n(stp_n), .ratio_strap_lo(s_lo), .ratio_strap_hi(s_hi),
    .insn_boundary(bnd), .higher_irq_pending(hip), .smm_resume(res), .snoop_req(snp),
    .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .irq(irq),
    .sys_mgmt_active_n(sa_n), .core_clk_en(ce), .exec_start(xs), .exec_resume(xr),
    .stop_grant_cycle(gnt), .snoop_ack(sak), .cache_inval(inv), .cache_inval_idx(idx),
    .wb_suppress(wbs), .reset_mode(mode), .ratio_sel(ratio));
  rsc_chipset_model chip_u (.sys_clk(sys_clk), .hw_reset(hwr), .cache_flush_req_n(fl_n),
    .soft_init(ini), .sys_mgmt_irq_n(smi_n), .core_clock_stop_req_n(stp_n),
    .ratio_strap_lo(s_lo), .ratio_strap_hi(s_hi));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [31:0] st_word(input logic c, input logic a, input logic [1:0] r,
                                          input logic [2:0] s, input logic p);
    return {22'h0, p, s, 2'h0, r, a, c};
  endfunction : st_word

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr   <= 1'b1;
    addr <= a;
    wd   <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    rd   <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask : reg_read

  // the read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_q) chk_word(rdat, exp_q.pop_front());
    if (gnt === 1'b1) gcnt++;
    rd_q <= rd;
  end

  task automatic reset_walk(input logic f, input logic t, input logic [1:0] code,
                            input bit open, input rsc_mode_type m, input rsc_ratio_type r);
    int k;
    k = 0;
    chip_u.set_strap(code, open);
    chip_u.reset_pulse(f, t);
    for (n = 0; n < 80 && xs !== 1'b1; n++) begin
      tick();
      if (inv === 1'b1) begin
        chk_word({29'h0, idx}, 32'(k));
        chk_bit(wbs, 1'b1);
        k++;
      end
    end
    chk_word(32'(k), 32'(LN));
    chk_bit(xs & ce & sa_n & ~wbs, 1'b1);
    chk_word({30'h0, mode}, {30'h0, m});
    chk_word({30'h0, ratio}, {30'h0, r});
    chip_u.mode_idle();
  endtask : reset_walk

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    {rst_b, bnd, hip, res, snp, wr, rd, addr, wd} = '0;
    lfsr = 32'h000152f8;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    reset_walk(1'b1, 1'b0, 2'b00, 1'b1, MODE_NORMAL, RATIO_1_2);
    for (i = 0; i < 4; i++) reset_walk(tf[i], ti[i], sc[i], 1'b0, em[i], er[i]);
    chip_u.set_strap(2'b10, 1'b0);
    repeat (4) tick();
    chk_word({30'h0, ratio}, {30'h0, RATIO_1_3});
    reg_read(OFS_STATE, st_word(1'b1, 1'b1, 2'h1, 3'h3, 1'b0));
    chip_u.smi_pulse();
    repeat (6) tick();
    chk_bit(sa_n, 1'b1);
    reg_read(OFS_STATE, st_word(1'b1, 1'b1, 2'h1, 3'h3, 1'b1));
    @(posedge sys_clk);
    bnd <= 1'b1;
    @(posedge sys_clk);
    bnd <= 1'b0;
    repeat (2) tick();
    for (i = 0; i < 8; i++) begin
      chk_bit(sa_n, 1'b0);
      tick();
    end
    reg_read(OFS_STATE, st_word(1'b1, 1'b0, 2'h1, 3'h7, 1'b0));
    @(posedge sys_clk);
    res <= 1'b1;
    @(posedge sys_clk);
    res <= 1'b0;
    repeat (3) tick();
    chk_bit(sa_n, 1'b1);
    reg_read(OFS_STATUS, 32'h5);
    reg_write(OFS_MASK, 32'h1);
    repeat (3) tick();
    chk_bit(irq, 1'b1);
    reg_write(OFS_STATUS, 32'h1);
    repeat (3) tick();
    chk_bit(irq, 1'b0);
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      reg_write(OFS_MASK, lfsr);
      reg_read(OFS_MASK, {29'h0, lfsr[2:0]});
      repeat (2) tick();
      chk_bit(irq, lfsr[2]);
    end
    reg_write(OFS_MASK, 32'h0);
    reg_write(4'hc, 32'hffffffff);
    reg_read(4'hc, 32'h0);
    reg_read(OFS_MASK, 32'h0);
    @(posedge sys_clk);
    bnd <= 1'b1;
    hip <= 1'b1;
    chip_u.set_stop(1'b0);
    repeat (8) tick();
    chk_bit(ce & (gcnt == 0), 1'b1);
    @(posedge sys_clk);
    hip <= 1'b0;
    for (n = 0; n < 10 && gnt !== 1'b1; n++) tick();
    chk_bit(gnt, 1'b1);
    repeat (2) tick();
    chk_bit(ce, 1'b0);
    chk_word(32'(gcnt), 32'h1);
    reg_read(OFS_STATE, st_word(1'b0, 1'b1, 2'h1, 3'h6, 1'b0));
    for (i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge sys_clk);
      snp <= lfsr[0];
      tick();
      chk_bit(sak, lfsr[0]);
    end
    chip_u.set_stop(1'b1);
    for (n = 0; n < 12 && xr !== 1'b1; n++) tick();
    chk_bit(xr & ce, 1'b1);
    reg_read(OFS_STATUS, 32'h6);
    repeat (3) tick();
    final_report();
  end
endmodule : testbench
